// *** life_monitor_pkg.sv ***
// Types shared by the part life monitor.
// Assumes the constants of life_monitor_regs.svh.
package life_monitor_pkg;

	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] addr;
		logic [15:0] wdata;
	} bus_req_type;

	typedef struct packed {
		logic inrush_closure;
		logic main_power_ok;
		logic run_command;
		logic output_shutoff_input;
		logic temp_high;
	} pin_in_type;

	typedef struct packed {
		logic valid;
		logic error;
		logic [7:0] value;
	} cap_result_type;

	typedef enum logic [1:0] {phase_idle, phase_inject, phase_wait, phase_held} meas_phase_type;

endpackage : life_monitor_pkg

// *** life_monitor_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the part life monitor.
// Assumes a 250 MHz controller clock and a 16-bit plain register port.
`ifndef LIFE_MONITOR_REGS_SVH
`define LIFE_MONITOR_REGS_SVH

`define LM_ADDR_LIFE_STATUS 8'h00
`define LM_ADDR_INRUSH_LIFE 8'h04
`define LM_ADDR_CTRL_CAP_LIFE 8'h08
`define LM_ADDR_MAIN_CAP_LIFE 8'h0c
`define LM_ADDR_MEASURE_STATE 8'h10
`define LM_ADDR_ENERGIZE_TIME 8'h14
`define LM_ADDR_ALARM_SET_TIME 8'h18
`define LM_ADDR_TERM_SELECT_BASE 8'h1c
`define LM_ADDR_TERM_SELECT_STEP 8'h04

`define LM_BIT_CTRL_CAP 0
`define LM_BIT_MAIN_CAP 1
`define LM_BIT_FAN 2
`define LM_BIT_INRUSH 3

`define LM_LIFE_FULL 8'h64
`define LM_INRUSH_ALARM_LEVEL 8'h0a
`define LM_CTRL_ALARM_LEVEL 8'h0a
`define LM_MAIN_ALARM_LEVEL 8'h55
`define LM_CLOSURES_PER_PCT 14'h2710
`define LM_HOURS_PER_UNIT 7'h64
`define LM_TIME_CLAMP 14'h270e
`define LM_SET_TIME_RESET 14'h270f
`define LM_SET_TIME_DISABLE 14'h270f
`define LM_TERM_SELECT_RESET 8'h00

`define LM_MEAS_IDLE 4'h0
`define LM_MEAS_START 4'h1
`define LM_MEAS_RUNNING 4'h2
`define LM_MEAS_DONE 4'h3
`define LM_MEAS_FORCED 4'h8
`define LM_MEAS_ERROR 4'h9

`define LM_FN_LIFE_POS 8'h5a
`define LM_FN_LIFE_NEG 8'hbe
`define LM_FN_MAINT_POS 8'h5f
`define LM_FN_MAINT_NEG 8'hc3

`define LM_CLOCK_PERIOD_NS 4
`define LM_DC_TIME_NS 1000000000
`define LM_DC_CYCLES (`LM_DC_TIME_NS / `LM_CLOCK_PERIOD_NS)

`endif

// *** part_life_monitor.sv ***
// Part life and maintenance monitor: wear counters, life alarm, capacitor measurement, hour meter.
// Assumes pins arrive asynchronously; hour_tick and cap_result come from logic on the same clock.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "life_monitor_regs.svh"

module part_life_monitor
	import life_monitor_pkg::*;
#(
	parameter int FANS = 2,
	parameter int TERMINALS = 3,
	parameter int DC_CYCLES = `LM_DC_CYCLES,
	parameter logic [15:0] CTRL_WEAR_PER_PCT = 16'h01f4
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire bus_req_type bus_req,
	output logic [15:0] rdata,
	input wire pin_in_type pins,
	input wire logic [FANS-1:0] fan_slow,
	input wire logic hour_tick,
	input wire cap_result_type cap_result,
	output logic dc_inject,
	output logic life_alarm_out,
	output logic maintenance_alarm_out,
	output logic fan_fault_indication,
	output logic maintenance_indication,
	output logic nvm_save,
	output logic [13:0] nvm_save_time,
	output logic [TERMINALS-1:0] terminal_out
);

	localparam int PINS = 5 + FANS;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
		hit = (addr == offset);
	endfunction : hit

	function automatic logic route(input logic [7:0] code, input logic life, input logic maint);
		route = ((code == `LM_FN_LIFE_POS) && life) || ((code == `LM_FN_LIFE_NEG) && !life)
			|| ((code == `LM_FN_MAINT_POS) && maint) || ((code == `LM_FN_MAINT_NEG) && !maint);
	endfunction : route

	// Pin synchronisers, a change counts once stages two and three agree
	logic [PINS-1:0] raw;
	logic [PINS-1:0] sync1_q;
	logic [PINS-1:0] sync2_q;
	logic [PINS-1:0] sync3_q;
	logic [PINS-1:0] clean_q;
	logic [PINS-1:0] prev_q;

	assign raw = {fan_slow, pins};

	genvar gi;
	generate
		for (gi = 0; gi < PINS; gi++)
		begin : g_sync
			always_ff @(posedge clock or negedge reset_n)
			begin
				if (!reset_n)
				begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
					sync3_q[gi] <= 1'b0;
					clean_q[gi] <= 1'b0;
					prev_q[gi] <= 1'b0;
				end
				else
				begin
					sync1_q[gi] <= raw[gi];
					sync2_q[gi] <= sync1_q[gi];
					sync3_q[gi] <= sync2_q[gi];
					clean_q[gi] <= (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : clean_q[gi];
					prev_q[gi] <= clean_q[gi];
				end
			end
		end
	endgenerate

	pin_in_type pin_now;
	pin_in_type pin_prev;
	logic fan_any;
	logic closure_event;
	logic power_rise;
	logic power_fall;
	logic invalid;
	logic hour_event;

	assign pin_now = clean_q[4:0];
	assign pin_prev = prev_q[4:0];
	assign fan_any = |clean_q[PINS-1:5];
	assign closure_event = pin_now.inrush_closure && !pin_prev.inrush_closure;
	assign power_rise = pin_now.main_power_ok && !pin_prev.main_power_ok;
	assign power_fall = !pin_now.main_power_ok && pin_prev.main_power_ok;
	assign invalid = pin_now.run_command || pin_now.output_shutoff_input;
	assign hour_event = hour_tick && pin_now.main_power_ok;

	// Register port decode
	logic wr_measure;
	logic wr_time;
	logic wr_set;
	assign wr_measure = bus_req.write && hit(bus_req.addr, `LM_ADDR_MEASURE_STATE);
	assign wr_time = bus_req.write && hit(bus_req.addr, `LM_ADDR_ENERGIZE_TIME);
	assign wr_set = bus_req.write && hit(bus_req.addr, `LM_ADDR_ALARM_SET_TIME);

	// Inrush limiter wear
	logic [13:0] closure_cnt_q;
	logic [13:0] closure_cnt_d;
	logic [7:0] inrush_life_q;
	logic [7:0] inrush_life_d;
	logic closure_wrap;

	assign closure_wrap = closure_cnt_q == (`LM_CLOSURES_PER_PCT - 14'h0001);
	assign closure_cnt_d = !(closure_event && inrush_life_q != 8'h00) ? closure_cnt_q
		: closure_wrap ? 14'h0000 : closure_cnt_q + 14'h0001;
	assign inrush_life_d = (closure_event && inrush_life_q != 8'h00 && closure_wrap)
		? inrush_life_q - 8'h01 : inrush_life_q;

	// Control capacitor wear, hot hours weigh double
	logic [15:0] wear_q;
	logic [15:0] wear_d;
	logic [15:0] wear_sum;
	logic [7:0] ctrl_life_q;
	logic [7:0] ctrl_life_d;
	logic wear_full;

	assign wear_sum = wear_q + (pins_hot_weight(pin_now.temp_high));
	assign wear_full = hour_event && ctrl_life_q != 8'h00 && wear_sum >= CTRL_WEAR_PER_PCT;
	assign wear_d = !hour_event ? wear_q : wear_full ? 16'h0000 : wear_sum;
	assign ctrl_life_d = wear_full ? ctrl_life_q - 8'h01 : ctrl_life_q;

	function automatic logic [15:0] pins_hot_weight(input logic hot);
		pins_hot_weight = hot ? 16'h0002 : 16'h0001;
	endfunction : pins_hot_weight

	// Energization hour meter
	logic [6:0] hour_cnt_q;
	logic [6:0] hour_cnt_d;
	logic [13:0] time_q;
	logic [13:0] time_d;
	logic [13:0] set_q;
	logic [13:0] set_d;
	logic hour_wrap;
	logic time_clear;

	assign time_clear = wr_time && bus_req.wdata == 16'h0000;
	assign hour_wrap = hour_event && hour_cnt_q == (`LM_HOURS_PER_UNIT - 7'h01);
	assign hour_cnt_d = time_clear ? 7'h00 : !hour_event ? hour_cnt_q
		: hour_wrap ? 7'h00 : hour_cnt_q + 7'h01;
	assign time_d = time_clear ? 14'h0000
		: (hour_wrap && time_q < `LM_TIME_CLAMP) ? time_q + 14'h0001 : time_q;
	assign set_d = (wr_set && bus_req.wdata <= {2'b00, `LM_SET_TIME_DISABLE})
		? bus_req.wdata[13:0] : set_q;

	logic maint_d;
	assign maint_d = set_q != `LM_SET_TIME_DISABLE && time_q >= set_q;

	// Main capacitor measurement sequencer
	meas_phase_type phase_q;
	meas_phase_type phase_d;
	logic [3:0] code_q;
	logic [3:0] code_d;
	logic [31:0] dc_cnt_q;
	logic [31:0] dc_cnt_d;
	logic [7:0] pend_q;
	logic [7:0] pend_d;
	logic [7:0] main_life_q;
	logic [7:0] main_life_d;
	logic sw_code_ok;

	assign sw_code_ok = wr_measure && (bus_req.wdata == {12'h000, `LM_MEAS_IDLE}
		|| bus_req.wdata == {12'h000, `LM_MEAS_START});

	always_comb
	begin
		phase_d = phase_q;
		code_d = sw_code_ok ? bus_req.wdata[3:0] : code_q;
		dc_cnt_d = dc_cnt_q;
		pend_d = pend_q;
		main_life_d = main_life_q;
		unique case (phase_q)
			phase_idle:
			begin
				if (power_fall && code_q == `LM_MEAS_START)
				begin
					phase_d = phase_inject;
					code_d = `LM_MEAS_RUNNING;
					dc_cnt_d = 32'h0000_0000;
				end
			end
			phase_inject, phase_wait:
			begin
				if (invalid)
				begin
					phase_d = phase_idle;
					code_d = `LM_MEAS_FORCED;
				end
				else if (cap_result.error)
				begin
					phase_d = phase_idle;
					code_d = `LM_MEAS_ERROR;
				end
				else if (power_rise)
				begin
					phase_d = phase_idle;
					code_d = `LM_MEAS_RUNNING;
				end
				else if (phase_q == phase_inject)
				begin
					if (dc_cnt_q == 32'(DC_CYCLES - 1))
						phase_d = phase_wait;
					else
						dc_cnt_d = dc_cnt_q + 32'h0000_0001;
				end
				else if (cap_result.valid)
				begin
					phase_d = phase_held;
					pend_d = cap_result.value;
				end
			end
			phase_held:
			begin
				if (power_rise)
				begin
					phase_d = phase_idle;
					code_d = `LM_MEAS_DONE;
					main_life_d = pend_q;
				end
			end
		endcase
	end

	// Status word and alarm
	logic [3:0] status_d;
	logic [3:0] status_q;
	assign status_d[`LM_BIT_CTRL_CAP] = ctrl_life_q < `LM_CTRL_ALARM_LEVEL;
	assign status_d[`LM_BIT_MAIN_CAP] = main_life_q <= `LM_MAIN_ALARM_LEVEL;
	assign status_d[`LM_BIT_FAN] = fan_any;
	assign status_d[`LM_BIT_INRUSH] = inrush_life_q <= `LM_INRUSH_ALARM_LEVEL;

	// Terminal routing
	logic [7:0] term_sel_q [TERMINALS];
	logic [TERMINALS-1:0] term_d;
	logic [TERMINALS-1:0] term_q;
	logic [TERMINALS-1:0] term_hit;
	logic life_alarm_q;
	logic maint_q;
	logic fan_ind_q;

	generate
		for (gi = 0; gi < TERMINALS; gi++)
		begin : g_term
			assign term_hit[gi] = bus_req.write && hit(bus_req.addr,
				8'(`LM_ADDR_TERM_SELECT_BASE + gi * `LM_ADDR_TERM_SELECT_STEP));
			assign term_d[gi] = route(term_sel_q[gi], |status_d, maint_d);
			always_ff @(posedge clock or negedge reset_n)
			begin
				if (!reset_n)
					term_sel_q[gi] <= `LM_TERM_SELECT_RESET;
				else if (term_hit[gi])
					term_sel_q[gi] <= bus_req.wdata[7:0];
			end
		end
	endgenerate

	// Read data, valid only in the cycle after the read strobe
	logic [15:0] rd_mux;
	logic [15:0] rd_term;
	logic [15:0] rdata_q;
	always_comb
	begin
		rd_term = 16'h0000;
		for (int i = 0; i < TERMINALS; i++)
			if (hit(bus_req.addr, 8'(`LM_ADDR_TERM_SELECT_BASE + i * `LM_ADDR_TERM_SELECT_STEP)))
				rd_term = {8'h00, term_sel_q[i]};
	end
	assign rd_mux = hit(bus_req.addr, `LM_ADDR_LIFE_STATUS) ? {12'h000, status_q}
		: hit(bus_req.addr, `LM_ADDR_INRUSH_LIFE) ? {8'h00, inrush_life_q}
		: hit(bus_req.addr, `LM_ADDR_CTRL_CAP_LIFE) ? {8'h00, ctrl_life_q}
		: hit(bus_req.addr, `LM_ADDR_MAIN_CAP_LIFE) ? {8'h00, main_life_q}
		: hit(bus_req.addr, `LM_ADDR_MEASURE_STATE) ? {12'h000, code_q}
		: hit(bus_req.addr, `LM_ADDR_ENERGIZE_TIME) ? {2'b00, time_q}
		: hit(bus_req.addr, `LM_ADDR_ALARM_SET_TIME) ? {2'b00, set_q}
		: rd_term;

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			closure_cnt_q <= 14'h0000;
			inrush_life_q <= `LM_LIFE_FULL;
			wear_q <= 16'h0000;
			ctrl_life_q <= `LM_LIFE_FULL;
			hour_cnt_q <= 7'h00;
			time_q <= 14'h0000;
			set_q <= `LM_SET_TIME_RESET;
		end
		else
		begin
			closure_cnt_q <= closure_cnt_d;
			inrush_life_q <= inrush_life_d;
			wear_q <= wear_d;
			ctrl_life_q <= ctrl_life_d;
			hour_cnt_q <= hour_cnt_d;
			time_q <= time_d;
			set_q <= set_d;
		end
	end

	logic dc_inject_q;
	logic nvm_save_q;
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			phase_q <= phase_idle;
			code_q <= `LM_MEAS_IDLE;
			dc_cnt_q <= 32'h0000_0000;
			pend_q <= `LM_LIFE_FULL;
			main_life_q <= `LM_LIFE_FULL;
			dc_inject_q <= 1'b0;
		end
		else
		begin
			phase_q <= phase_d;
			code_q <= code_d;
			dc_cnt_q <= dc_cnt_d;
			pend_q <= pend_d;
			main_life_q <= main_life_d;
			dc_inject_q <= phase_d == phase_inject;
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			status_q <= 4'h0;
			life_alarm_q <= 1'b0;
			maint_q <= 1'b0;
			fan_ind_q <= 1'b0;
			term_q <= '0;
			nvm_save_q <= 1'b0;
			rdata_q <= 16'h0000;
		end
		else
		begin
			status_q <= status_d;
			life_alarm_q <= |status_d;
			maint_q <= maint_d;
			fan_ind_q <= fan_any;
			term_q <= term_d;
			nvm_save_q <= hour_event;
			rdata_q <= bus_req.read ? rd_mux : 16'h0000;
		end
	end

	assign rdata = rdata_q;
	assign dc_inject = dc_inject_q;
	assign life_alarm_out = life_alarm_q;
	assign maintenance_alarm_out = maint_q;
	assign maintenance_indication = maint_q;
	assign fan_fault_indication = fan_ind_q;
	assign nvm_save = nvm_save_q;
	assign nvm_save_time = time_q;
	assign terminal_out = term_q;

	// Checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	sequence seq_armed_fall;
		phase_q == phase_idle && code_q == `LM_MEAS_START && power_fall;
	endsequence

	sequence seq_inject_begun;
		dc_inject_q && code_q == `LM_MEAS_RUNNING;
	endsequence

	sequence seq_spoiled;
		(phase_q == phase_inject || phase_q == phase_wait) && invalid;
	endsequence

	chk_alarm_or_bits: assert property (life_alarm_out == (|status_q))
		else $error("life alarm differs from status OR");
	chk_inrush_step: assert property (closure_event && closure_wrap && inrush_life_q != 8'h00
		|=> inrush_life_q == $past(inrush_life_q) - 8'h01)
		else $error("inrush life did not drop after 10000 closures");
	chk_inrush_alarm: assert property (inrush_life_q <= 8'h0a |=> status_q[3] && life_alarm_out)
		else $error("inrush alarm missing");
	chk_ctrl_alarm: assert property (ctrl_life_q < 8'h0a |=> status_q[0] && life_alarm_out)
		else $error("control capacitor alarm missing");
	chk_main_alarm: assert property ($changed(main_life_q) ##0 main_life_q <= 8'h55
		|=> status_q[1] && life_alarm_out)
		else $error("main capacitor alarm missing");
	chk_fan_alarm: assert property (fan_any |=> status_q[2] && fan_fault_indication)
		else $error("fan alarm missing");
	chk_done_not_written: assert property (wr_measure && bus_req.wdata == 16'h0003
		&& code_q != 4'h3 && phase_q != phase_held |=> code_q != 4'h3)
		else $error("code 3 accepted from a write");
	chk_measure_start: assert property (seq_armed_fall |=> seq_inject_begun)
		else $error("measurement did not start at power-off");
	chk_dc_bound: assert property (dc_inject_q |-> dc_cnt_q < 32'(DC_CYCLES))
		else $error("DC injection too long");
	chk_spoiled_forced: assert property (seq_spoiled |=> code_q == 4'h8 && !dc_inject_q)
		else $error("spoiled measurement not forced off");
	chk_time_clamp: assert property (time_q <= 14'h270e)
		else $error("timer value above clamp");
	chk_time_clear: assert property (time_clear |=> time_q == 14'h0000 && hour_cnt_q == 7'h00)
		else $error("timer not cleared by zero write");
	chk_maint_alarm: assert property (set_q != 14'h270f && time_q >= set_q
		|=> maintenance_alarm_out && maintenance_indication)
		else $error("maintenance alarm missing");
	chk_maint_off: assert property (set_q == 14'h270f |=> !maintenance_alarm_out)
		else $error("maintenance alarm while disabled");

endmodule : part_life_monitor
`default_nettype wire

// *** plant_model.sv ***
// Far side of the life monitor: power stage, capacitor probe, fans and limiter contact.
// Assumes the bench steers it by plain levels on the monitor clock.
`timescale 1ns/1ns
`default_nettype none
module plant_model
	import life_monitor_pkg::*;
#(
	parameter logic [7:0] RESULT = 8'h55,
	parameter int RESULT_DELAY = 3
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic dc_inject,
	input wire logic power_on,
	input wire logic run_cmd,
	input wire logic shutoff,
	input wire logic hold_result,
	input wire logic [1:0] fan_set,
	input wire logic closure_en,
	output pin_in_type pins,
	output logic [1:0] fan_slow,
	output cap_result_type cap_result,
	output int closures
);
	logic dc_q;
	logic valid_q;
	logic closure_q;
	int wait_q;
	int ph_q;
	assign pins = '{closure_q, power_on, run_cmd, shutoff, 1'b0};
	assign fan_slow = fan_set;
	// Value lines idle at the inverse of the result
	assign cap_result = '{valid_q, 1'b0, valid_q ? RESULT : ~RESULT};
	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dc_q <= 1'b0;
			valid_q <= 1'b0;
			wait_q <= 0;
			ph_q <= 0;
			closure_q <= 1'b0;
			closures <= 0;
		end
		else
		begin
			dc_q <= dc_inject;
			valid_q <= 1'b0;
			// Probe answers after the DC pulse unless held or disturbed
			if (dc_q && !dc_inject && !hold_result && !run_cmd && !shutoff)
				wait_q <= RESULT_DELAY;
			else if (wait_q > 1)
				wait_q <= wait_q - 1;
			else if (wait_q == 1)
			begin
				wait_q <= 0;
				valid_q <= 1'b1;
			end
			// Limiter contact closes for 2 cycles of every 4, the shortest the pin filter passes
			ph_q <= (closure_en && ph_q < 3) ? ph_q + 1 : 0;
			closure_q <= closure_en && ph_q < 2;
			if (closure_en && ph_q == 0)
				closures <= closures + 1;
		end
	end
endmodule : plant_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench of the part life monitor.
// Assumes plant_model on the far side and short DC and wear counts.
`timescale 1ns/1ns
`default_nettype none
`include "life_monitor_regs.svh"
`define CHK(got, exp) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) \
		begin \
			error_cnt++; \
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end
module tb_top;
	import life_monitor_pkg::*;
	logic clock;
	logic reset_n;
	bus_req_type req;
	logic [15:0] rdata;
	pin_in_type pins;
	logic [1:0] fan_slow;
	logic hour_tick;
	cap_result_type cap_result;
	logic dc_inject;
	logic life_alarm_out;
	logic maintenance_alarm_out;
	logic fan_fault_indication;
	logic maintenance_indication;
	logic nvm_save;
	logic [13:0] nvm_save_time;
	logic [2:0] terminal_out;
	logic power_on;
	logic run_cmd;
	logic shutoff;
	logic hold;
	logic [1:0] fan_set;
	logic closure_en;
	int closures;
	int error_cnt;
	int tests_run;
	int saves;
	int k;
	logic [15:0] v;

	part_life_monitor #(.DC_CYCLES(20), .CTRL_WEAR_PER_PCT(16'h0002)) i_dut (.clock(clock),
		.reset_n(reset_n), .bus_req(req), .rdata(rdata), .pins(pins), .fan_slow(fan_slow),
		.hour_tick(hour_tick), .cap_result(cap_result), .dc_inject(dc_inject),
		.life_alarm_out(life_alarm_out), .maintenance_alarm_out(maintenance_alarm_out),
		.fan_fault_indication(fan_fault_indication),
		.maintenance_indication(maintenance_indication), .nvm_save(nvm_save),
		.nvm_save_time(nvm_save_time), .terminal_out(terminal_out));

	plant_model i_plant (.clock(clock), .reset_n(reset_n), .dc_inject(dc_inject),
		.power_on(power_on), .run_cmd(run_cmd), .shutoff(shutoff), .hold_result(hold),
		.fan_set(fan_set), .closure_en(closure_en), .pins(pins), .fan_slow(fan_slow),
		.cap_result(cap_result), .closures(closures));

	always #2 clock = ~clock;
	always @(posedge clock)
		if (nvm_save === 1'b1)
			saves++;

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clock);
		req <= '0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clock);
		req <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clock);
		req <= '0;
		#1;
		d = rdata;
	endtask : rd

	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		rd(a, v);
		`CHK(v, e)
	endtask : rchk

	task automatic ticks(input int n);
		repeat (n)
		begin
			@(posedge clock);
			hour_tick <= 1'b1;
			@(posedge clock);
			hour_tick <= 1'b0;
		end
		repeat (3) @(posedge clock);
	endtask : ticks

	task automatic wait_dc();
		for (k = 0; k < 40 && dc_inject !== 1'b1; k++)
		begin
			@(posedge clock);
			#1;
		end
	endtask : wait_dc

	task automatic final_report();
		if (error_cnt == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	initial
	begin
		#200000;
		error_cnt++;
		final_report();
	end

	initial
	begin
		clock = 0;
		reset_n = 0;
		req = '0;
		hour_tick = 0;
		{power_on, run_cmd, shutoff, hold, fan_set, closure_en} = 7'h40;
		{error_cnt, tests_run, saves} = '0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		repeat (8) @(posedge clock);
		rchk(`LM_ADDR_LIFE_STATUS, 16'h0000);
		rchk(`LM_ADDR_INRUSH_LIFE, 16'h0064);
		rchk(`LM_ADDR_CTRL_CAP_LIFE, 16'h0064);
		rchk(`LM_ADDR_MAIN_CAP_LIFE, 16'h0064);
		rchk(`LM_ADDR_ENERGIZE_TIME, 16'h0000);
		rchk(`LM_ADDR_ALARM_SET_TIME, 16'h270f);
		rchk(8'hfc, 16'h0000);
		`CHK({life_alarm_out, maintenance_alarm_out}, 2'b00)
		wr(`LM_ADDR_TERM_SELECT_BASE, 16'h005a);
		wr(8'h20, 16'h00be);
		wr(8'h24, 16'h005f);
		repeat (3) @(posedge clock);
		`CHK(terminal_out, 3'b010)
		wr(`LM_ADDR_MEASURE_STATE, 16'h0003);
		rchk(`LM_ADDR_MEASURE_STATE, 16'h0000);
		wr(`LM_ADDR_MEASURE_STATE, 16'h0008);
		rchk(`LM_ADDR_MEASURE_STATE, 16'h0000);
		wr(`LM_ADDR_MEASURE_STATE, 16'h0001);
		rchk(`LM_ADDR_MEASURE_STATE, 16'h0001);
		// Good measurement across a power cycle
		power_on <= 1'b0;
		wait_dc();
		for (k = 0; k < 100 && dc_inject === 1'b1; k++)
		begin
			@(posedge clock);
			#1;
		end
		`CHK(k, 20)
		repeat (10) @(posedge clock);
		power_on <= 1'b1;
		v = 0;
		for (k = 0; k < 30 && v !== 16'h0003; k++)
			rd(`LM_ADDR_MEASURE_STATE, v);
		`CHK(v, 16'h0003)
		rchk(`LM_ADDR_MAIN_CAP_LIFE, 16'h0055);
		rchk(`LM_ADDR_LIFE_STATUS, 16'h0002);
		`CHK(life_alarm_out, 1'b1)
		`CHK(terminal_out, 3'b001)
		// Run command during injection
		wr(`LM_ADDR_MEASURE_STATE, 16'h0001);
		power_on <= 1'b0;
		wait_dc();
		run_cmd <= 1'b1;
		repeat (10) @(posedge clock);
		`CHK(dc_inject, 1'b0)
		rchk(`LM_ADDR_MEASURE_STATE, 16'h0008);
		run_cmd <= 1'b0;
		power_on <= 1'b1;
		// Power back before a result
		hold <= 1'b1;
		wr(`LM_ADDR_MEASURE_STATE, 16'h0001);
		power_on <= 1'b0;
		wait_dc();
		power_on <= 1'b1;
		repeat (40) @(posedge clock);
		rchk(`LM_ADDR_MEASURE_STATE, 16'h0002);
		hold <= 1'b0;
		fan_set <= 2'b10;
		repeat (8) @(posedge clock);
		`CHK(fan_fault_indication, 1'b1)
		rchk(`LM_ADDR_LIFE_STATUS, 16'h0006);
		fan_set <= 2'b00;
		repeat (8) @(posedge clock);
		`CHK(fan_fault_indication, 1'b0)
		wr(`LM_ADDR_ALARM_SET_TIME, 16'h2710);
		rchk(`LM_ADDR_ALARM_SET_TIME, 16'h270f);
		wr(`LM_ADDR_ALARM_SET_TIME, 16'h0001);
		ticks(99);
		rchk(`LM_ADDR_ENERGIZE_TIME, 16'h0000);
		`CHK(maintenance_alarm_out, 1'b0)
		ticks(1);
		rchk(`LM_ADDR_ENERGIZE_TIME, 16'h0001);
		`CHK({maintenance_alarm_out, maintenance_indication}, 2'b11)
		`CHK(terminal_out, 3'b101)
		`CHK(saves, 100)
		`CHK(nvm_save_time, 14'h0001)
		ticks(80);
		rchk(`LM_ADDR_CTRL_CAP_LIFE, 16'h000a);
		rchk(`LM_ADDR_LIFE_STATUS, 16'h0002);
		ticks(2);
		rchk(`LM_ADDR_CTRL_CAP_LIFE, 16'h0009);
		rchk(`LM_ADDR_LIFE_STATUS, 16'h0003);
		wr(`LM_ADDR_ENERGIZE_TIME, 16'h0005);
		rchk(`LM_ADDR_ENERGIZE_TIME, 16'h0001);
		wr(`LM_ADDR_ENERGIZE_TIME, 16'h0000);
		rchk(`LM_ADDR_ENERGIZE_TIME, 16'h0000);
		`CHK(maintenance_alarm_out, 1'b0)
		wr(`LM_ADDR_ALARM_SET_TIME, 16'h0000);
		repeat (3) @(posedge clock);
		`CHK(maintenance_alarm_out, 1'b1)
		wr(`LM_ADDR_ALARM_SET_TIME, 16'h270f);
		repeat (3) @(posedge clock);
		`CHK(maintenance_alarm_out, 1'b0)
		closure_en <= 1'b1;
		for (k = 0; k < 45000 && closures < 10000; k++)
			@(posedge clock);
		closure_en <= 1'b0;
		repeat (12) @(posedge clock);
		rchk(`LM_ADDR_INRUSH_LIFE, 16'h0063);
		final_report();
	end
endmodule : tb_top
`default_nettype wire
